// >>> verilog/adc_seq_pkg.sv
// shared types and constants for the a/d conversion sequencer
// assumes a single 20 mhz system clock and synchronous active-high reset
package adc_seq_pkg;

    // conversion phase lengths in conversion clock periods
    localparam logic [4:0] SAMPLE_PERIODS  = 5'h04;
    localparam logic [4:0] CONVERT_PERIODS = 5'h0c;
    localparam logic [4:0] TOTAL_PERIODS   = 5'h10;

    // divider codes, 000 = undivided, 111 = /128
    localparam int         DIV_BITS        = 3;
    localparam logic [6:0] DIV_CNT_ZERO    = 7'h00;

    // input routing codes
    localparam logic [3:0] SRC_EXTERNAL    = 4'h0;
    localparam logic [1:0] SRC_PGA_GROUP   = 2'h1;   // upper source bits 01 pick the pga output
    localparam logic [3:0] LAST_CHANNEL    = 4'hb;
    localparam int         NUM_CHANNELS    = 12;

    // result layout
    localparam int         RESULT_BITS     = 12;
    localparam logic [11:0] RESULT_ZERO    = 12'h000;
    localparam logic [11:0] RESULT_FULL    = 12'hfff;
    localparam logic [3:0]  PAD_ZERO       = 4'h0;

    // reference codes: 00 supply, 01 pin, 1x pga
    localparam logic [1:0] REF_SUPPLY      = 2'h0;
    localparam logic [1:0] REF_PIN         = 2'h1;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARMED   = 2'b01,
        ST_SAMPLE  = 2'b10,
        ST_CONVERT = 2'b11
    } seq_state_t;

    // software-facing configuration
    typedef struct packed {
        logic       power_enable;
        logic [2:0] clock_divider_select;
        logic [3:0] input_source_select;
        logic [3:0] external_channel_select;
        logic       result_format_select;
        logic [1:0] reference_select;
        logic       pga_input_select;
        logic [1:0] pga_gain_select;
    } adc_config_t;

    // analog routing controls toward the converter core
    typedef struct packed {
        logic                    core_power;
        logic [NUM_CHANNELS-1:0] channel_connect;
        logic                    internal_connect;
        logic [3:0]              internal_source;
        logic [1:0]              reference_route;
        logic                    pga_route;
        logic                    pga_input_select;
        logic [1:0]              pga_gain_select;
        logic                    sample_hold;
    } adc_route_t;

endpackage

// >>> verilog/adc_clock_divider.sv
// conversion clock enable generator
// produces a one-cycle tick every 2**code system clocks; restart realigns phase
`timescale 1ns/10ps
module adc_clock_divider (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       restart,
    input  wire logic [2:0] divider_select,
    output logic            tick
);
    logic [6:0] count_reg;   // free count of system clocks
    logic [6:0] mask;        // low bits that must all be ones

    // mask of code ones, value 2**code - 1
    always_comb begin
        mask = 7'((8'h01 << divider_select) - 8'h01);
    end

    // count runs every cycle; restart aligns to the new conversion
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            count_reg <= adc_seq_pkg::DIV_CNT_ZERO;
        end else begin
            count_reg <= count_reg + 7'h01;
        end
    end

    // tick when all masked bits are set and restart is low, code 000 ticks on every cycle without restart
    assign tick = ((count_reg & mask) == mask) && !restart;
endmodule

// >>> verilog/adc_sequencer.sv
// a/d conversion sequencer: start pulse, busy, interrupt request, timing
// assumes one 20 mhz clock; control bits come from cpu logic on that clock
`timescale 1ns/10ps
module adc_sequencer (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     start,
    input  wire adc_seq_pkg::adc_config_t cfg,
    input  wire logic                     adc_interrupt_enable,
    input  wire logic                     interrupt_clear,
    input  wire logic                     interrupt_serviced,
    input  wire logic                     core_bit,
    output logic                          conversion_busy_flag,
    output logic                          adc_interrupt_request,
    output logic                          adc_interrupt,
    output logic [7:0]                    result_high_byte,
    output logic [7:0]                    result_low_byte,
    output logic [3:0]                    trial_bit,
    output adc_seq_pkg::adc_route_t       route
);
    adc_seq_pkg::seq_state_t state_reg;   // sequencer phase
    logic                    start_reg;   // previous start level
    logic [4:0]              period_reg;  // conversion clocks elapsed
    logic [11:0]             sar_reg;     // successive approximation word
    logic [11:0]             result_reg;  // last completed result
    logic [11:0]             result_next; // result word this edge leaves
    logic                    busy_reg;    // busy flag
    logic                    irq_reg;     // sticky request flag
    logic                    start_rise;  // start went high
    logic                    start_fall;  // start went low
    logic                    tick;        // conversion clock enable
    logic                    done;        // last conversion period ends
    logic                    external_src; // source is an external pin

    // edges of the start level; start is cpu logic on this clock, so no synchroniser
    assign start_rise = start && !start_reg;
    assign start_fall = !start && start_reg;
    // last tick of the sixteenth conversion period
    assign done = (state_reg == adc_seq_pkg::ST_CONVERT) && tick
                  && (period_reg == adc_seq_pkg::TOTAL_PERIODS - 5'h01);

    // conversion clock from the system clock
    // restart on the launch edge keeps every conversion at exactly sixteen ticks
    adc_clock_divider u_div (
        .clk            (clk),
        .rst            (rst),
        .restart        (start_fall),
        .divider_select (cfg.clock_divider_select),
        .tick           (tick)
    );

    // start level history for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= start;
        end
    end

    // phase sequencing; runs without any cpu handshake
    always_ff @(posedge clk) begin
        if (rst || !cfg.power_enable) begin
            state_reg <= adc_seq_pkg::ST_IDLE;
        end else if (start_rise) begin
            state_reg <= adc_seq_pkg::ST_ARMED;
        end else begin
            case (state_reg)
                adc_seq_pkg::ST_IDLE: begin
                    // leaves only on a start rise, taken above
                    state_reg <= adc_seq_pkg::ST_IDLE;
                end
                adc_seq_pkg::ST_ARMED: begin
                    // only a complete high-low pulse launches
                    if (start_fall) begin
                        state_reg <= adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (tick && period_reg == adc_seq_pkg::SAMPLE_PERIODS - 5'h01) begin
                        state_reg <= adc_seq_pkg::ST_CONVERT;
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (done) begin
                        state_reg <= adc_seq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // conversion clock period counter
    // held at zero until sampling opens, so the first tick ends period 0
    always_ff @(posedge clk) begin
        if (rst || state_reg == adc_seq_pkg::ST_IDLE || state_reg == adc_seq_pkg::ST_ARMED) begin
            period_reg <= 5'h00;
        end else if (tick) begin
            period_reg <= period_reg + 5'h01;
        end
    end

    // successive approximation, msb first over the twelve converting periods
    // index wraps for the one cycle after done; nothing reads it then
    assign trial_bit = 4'(adc_seq_pkg::TOTAL_PERIODS - 5'h01 - period_reg);

    always_ff @(posedge clk) begin
        if (rst || state_reg == adc_seq_pkg::ST_SAMPLE) begin
            sar_reg <= adc_seq_pkg::RESULT_ZERO;
        end else if (state_reg == adc_seq_pkg::ST_CONVERT && tick) begin
            sar_reg[trial_bit] <= core_bit;
        end
    end

    // next result word; the last decision goes in directly, so the word and
    // the bytes below are written on the very edge that clears busy
    always_comb begin
        result_next = result_reg;
        if (done) begin
            result_next = {sar_reg[11:1], core_bit};
        end
    end

    // result held until the next completion
    always_ff @(posedge clk) begin
        if (rst) begin
            result_reg <= adc_seq_pkg::RESULT_ZERO;
        end else begin
            result_reg <= result_next;
        end
    end

    // byte arrangement: 0 left aligned, 1 right aligned
    // bytes follow the format bit at once, so change it only while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            result_high_byte <= 8'h00;
            result_low_byte  <= 8'h00;
        end else if (cfg.result_format_select) begin
            result_high_byte <= {adc_seq_pkg::PAD_ZERO, result_next[11:8]};
            result_low_byte  <= result_next[7:0];
        end else begin
            result_high_byte <= result_next[11:4];
            result_low_byte  <= {result_next[3:0], adc_seq_pkg::PAD_ZERO};
        end
    end

    // busy from successful launch until completion or abort
    always_ff @(posedge clk) begin
        if (rst || !cfg.power_enable || start_rise) begin
            busy_reg <= 1'b0;
        end else if (state_reg == adc_seq_pkg::ST_ARMED && start_fall) begin
            busy_reg <= 1'b1;
        end else if (done) begin
            busy_reg <= 1'b0;
        end
    end

    // sticky request; completion beats a simultaneous clear
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else if (done) begin
            irq_reg <= 1'b1;
        end else if (interrupt_clear || interrupt_serviced) begin
            irq_reg <= 1'b0;
        end
    end

    // busy and request leave straight from their registers; the interrupt is the request gated by the enable
    assign conversion_busy_flag  = busy_reg;
    assign adc_interrupt_request = irq_reg;
    assign adc_interrupt         = irq_reg && adc_interrupt_enable;

    // analog routing controls, one connect line per channel
    genvar ch;
    generate
        for (ch = 0; ch < adc_seq_pkg::NUM_CHANNELS; ch = ch + 1) begin : g_chan
            assign route.channel_connect[ch] = cfg.power_enable
                && external_src
                && cfg.external_channel_select == 4'(ch);
        end
    endgenerate

    // routing follows the configuration live; nothing is held per conversion
    assign external_src           = cfg.input_source_select == adc_seq_pkg::SRC_EXTERNAL;
    assign route.core_power       = cfg.power_enable;
    assign route.internal_connect = cfg.power_enable && !external_src;
    assign route.internal_source  = cfg.input_source_select;
    assign route.reference_route  = cfg.reference_select;
    // only the 01xx source group and the 1x references use the pga output
    assign route.pga_route        = cfg.reference_select[1]
                                    || cfg.input_source_select[3:2] == adc_seq_pkg::SRC_PGA_GROUP;
    assign route.pga_input_select = cfg.pga_input_select;
    assign route.pga_gain_select  = cfg.pga_gain_select;
    assign route.sample_hold      = state_reg == adc_seq_pkg::ST_SAMPLE;
endmodule

// >>> verif/adc_sequencer_sva.sv
// assertion checker for the a/d conversion sequencer ports
// assumes one clock clk with synchronous active-high rst; bound into adc_sequencer
`timescale 1ns/10ps
module adc_sequencer_sva (
    input wire logic                     clk,
    input wire logic                     rst,
    input wire logic                     start,
    input wire adc_seq_pkg::adc_config_t cfg,
    input wire logic                     adc_interrupt_enable,
    input wire logic                     interrupt_clear,
    input wire logic                     interrupt_serviced,
    input wire logic                     core_bit,
    input wire logic                     conversion_busy_flag,
    input wire logic                     adc_interrupt_request,
    input wire logic                     adc_interrupt,
    input wire logic [7:0]               result_high_byte,
    input wire logic [7:0]               result_low_byte,
    input wire logic [3:0]               trial_bit,
    input wire adc_seq_pkg::adc_route_t  route
);
    // single domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_busy_after_start: assert property ($fell(start) && cfg.power_enable |-> ##[1:2] conversion_busy_flag)
        else $error("busy did not follow the start pulse");
    a_request_on_done: assert property ($fell(conversion_busy_flag) && !$past(start) && $past(cfg.power_enable)
        |-> adc_interrupt_request)
        else $error("completion without request");
    a_irq_gated: assert property (adc_interrupt == (adc_interrupt_request && adc_interrupt_enable))
        else $error("interrupt not request and enable");
    a_power_idle: assert property (!cfg.power_enable |-> !route.core_power ##1 !conversion_busy_flag)
        else $error("busy or powered while disabled");
    a_internal_off: assert property (cfg.input_source_select != 4'h0 |-> route.channel_connect == 12'h000)
        else $error("external channel left connected");
    a_channel_pick: assert property (cfg.power_enable && cfg.input_source_select == 4'h0 |-> route.channel_connect ==
        ((cfg.external_channel_select <= 4'hb) ? 12'h001 << cfg.external_channel_select : 12'h000))
        else $error("wrong channel connected");
    a_request_stays: assert property (adc_interrupt_request && !interrupt_clear && !interrupt_serviced
        |=> adc_interrupt_request)
        else $error("request dropped by itself");
    a_clear_idle: assert property (interrupt_clear && !conversion_busy_flag |=> !adc_interrupt_request)
        else $error("clear ignored");
    a_result_steady: assert property (conversion_busy_flag && $past(conversion_busy_flag)
        |-> $stable(result_high_byte) && $stable(result_low_byte))
        else $error("result moved during conversion");
    a_sample_first: assert property ($rose(conversion_busy_flag) |-> route.sample_hold)
        else $error("conversion did not open with sampling");
endmodule

bind adc_sequencer adc_sequencer_sva u_adc_sequencer_sva (.clk(clk), .rst(rst), .start(start), .cfg(cfg),
    .adc_interrupt_enable(adc_interrupt_enable), .interrupt_clear(interrupt_clear),
    .interrupt_serviced(interrupt_serviced), .core_bit(core_bit), .conversion_busy_flag(conversion_busy_flag),
    .adc_interrupt_request(adc_interrupt_request), .adc_interrupt(adc_interrupt),
    .result_high_byte(result_high_byte), .result_low_byte(result_low_byte), .trial_bit(trial_bit), .route(route));

// >>> verif/tb.sv
// self-checking bench for the a/d conversion sequencer
// assumes the package is compiled first and the checker is bound in
`timescale 1ns/10ps
module tb;
    logic                     clk = 1'b0;      // 20 mhz system clock
    logic                     rst = 1'b1;      // held 8 cycles
    logic                     start = 1'b0;    // software start bit
    logic                     ie = 1'b0;       // interrupt enable
    logic                     iclr = 1'b0;     // request clear
    logic                     isrv = 1'b0;     // request serviced
    logic                     core_bit = 1'b0; // comparator answer
    adc_seq_pkg::adc_config_t cfg = '0;
    adc_seq_pkg::adc_route_t  route;
    logic                     busy, req, irq;
    logic [7:0]               hi, lo;
    logic [3:0]               trial;
    logic [15:0]              val = 16'h0000;  // analog level the comparator stands for
    int                       err_count = 0;
    int                       n_tests = 0;
    int                       seed = 32'h4d7f;
    int                       n, e;

    always #25 clk = ~clk;

    adc_sequencer u_adc_sequencer (.clk(clk), .rst(rst), .start(start), .cfg(cfg), .adc_interrupt_enable(ie),
        .interrupt_clear(iclr), .interrupt_serviced(isrv), .core_bit(core_bit), .conversion_busy_flag(busy),
        .adc_interrupt_request(req), .adc_interrupt(irq), .result_high_byte(hi), .result_low_byte(lo),
        .trial_bit(trial), .route(route));

    // comparator model: answers the bit under trial, so the result must equal val[11:0]
    always @(negedge clk) core_bit <= val[trial];

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // bounded wait on busy, leaves the cycle count in n
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busy !== lvl) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                err_count++;
                wrap_up;
            end
        end
    endtask

    task automatic pulse; // high for one cycle, then low
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask

    // one conversion at divider code c with random value (all ones at code 0), format and enable
    task automatic convert(input int c);
        logic fmt;
        fmt = 1'($random(seed));
        val = 16'($random(seed));
        if (c == 0) begin
            val = 16'hffff;
        end
        ie = 1'($random(seed));
        @(negedge clk);
        cfg.clock_divider_select = 3'(c);
        cfg.result_format_select = fmt;
        pulse();
        wait_busy(1'b1, 4);
        wait_busy(1'b0, (16 << c) + 4);
        check(16'(n), 16'(16 << c), "busy length");
        check(16'(req), 16'h0001, "request");
        check(16'(irq), 16'(ie), "interrupt");
        repeat (2) @(negedge clk);
        e = fmt ? int'(val[11:0]) : int'(val[11:0]) << 4;
        check(16'(hi), 16'(e >> 8), "high byte");
        check(16'(lo), 16'(e & 255), "low byte");
        check(16'(req), 16'h0001, "sticky request");
        if (c % 2 == 1) isrv = 1'b1; // alternate the two ways out
        else iclr = 1'b1;
        @(negedge clk);
        {isrv, iclr} = 2'b00;
        check(16'(req), 16'h0000, "cleared request");
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(16'({busy, req, irq}), 16'h0000, "reset flags");
        check({hi, lo}, 16'h0000, "reset result");
        pulse(); // power still off, so the start is refused
        repeat (4) @(negedge clk);
        check(16'({busy, route.core_power, route.channel_connect}), 16'h0000, "powered off");
        cfg.power_enable = 1'b1;
        // sweep every source and channel code while idle, one pair per cycle
        for (int s = 0; s < 16; s++) for (int ch = 0; ch < 16; ch++) begin
            @(negedge clk);
            cfg.input_source_select = 4'(s);
            cfg.external_channel_select = 4'(ch);
            #1 check(16'(route.channel_connect), (s == 0 && ch < 12) ? 16'(1 << ch) : 16'h0,
                "channels");
            check(16'({route.internal_connect, route.pga_route, route.internal_source}),
                16'({s != 0, s / 4 == 1, 4'(s)}), "internal route");
        end
        // every reference code, with the pga settings passed along
        for (int r = 0; r < 4; r++) begin
            @(negedge clk);
            cfg.reference_select = 2'(r);
            cfg.pga_input_select = 1'(r);
            cfg.pga_gain_select = 2'(3 - r);
            #1 check(16'({route.reference_route, route.pga_route, route.pga_input_select, route.pga_gain_select}),
                16'({2'(r), r > 1, 1'(r), 2'(3 - r)}), "reference route");
        end
        repeat (10) @(negedge clk);
        for (int c = 0; c < 8; c++) convert(c);
        // a second rise mid-run aborts; the fall relaunches with full timing
        cfg.clock_divider_select = 3'h4;
        pulse();
        repeat (20) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        check(16'({busy, req}), 16'h0000, "aborted");
        start = 1'b0;
        wait_busy(1'b1, 4);
        wait_busy(1'b0, 260);
        check(16'(n), 16'd256, "relaunch length");
        check(16'(req), 16'h0001, "relaunch request");
        // converter switched off once it is no longer needed
        cfg.power_enable = 1'b0;
        @(negedge clk);
        check(16'({busy, route.core_power, route.channel_connect}), 16'h0000, "released");
        wrap_up;
    end
endmodule
